// ==== design/osc_regs.svh ====
// Register indices, field positions, codes and reset values of the amplifier
// control bank. Assumes inclusion by bare name from the package and the module.
`ifndef OSC_REGS_SVH
`define OSC_REGS_SVH

// ----------------------------------------------------------------------------
// Register indices; the bus byte address is four times the index.
// ----------------------------------------------------------------------------
`define OSC_IDX_AMP0_A 8'hc0
`define OSC_IDX_AMP0_B 8'hc1
`define OSC_IDX_AMP1_A 8'hc2
`define OSC_IDX_AMP1_B 8'hc3
`define OSC_IDX_SW_WORD 8'hce
`define OSC_IDX_SW_LOW 8'hcf

// ----------------------------------------------------------------------------
// Reset values, all cleared by power-up clear.
// ----------------------------------------------------------------------------
`define OSC_RST_BYTE 8'h00
`define OSC_RST_WORD 16'h0000

// ----------------------------------------------------------------------------
// Field positions of control register a.
// ----------------------------------------------------------------------------
`define OSC_A_INV_HI 7
`define OSC_A_INV_LO 6
`define OSC_A_NONINV_HI 5
`define OSC_A_NONINV_LO 4
`define OSC_A_SLEW_HI 3
`define OSC_A_SLEW_LO 2

// ----------------------------------------------------------------------------
// Field positions of control register b.
// ----------------------------------------------------------------------------
`define OSC_B_FUNC_HI 4
`define OSC_B_FUNC_LO 2
`define OSC_B_CAL 1

// ----------------------------------------------------------------------------
// Field positions of the switch control low byte.
// ----------------------------------------------------------------------------
`define OSC_SW_AMP1_SHUNT 7
`define OSC_SW_GROUND 6
`define OSC_SW_FORCE_A_HI 5
`define OSC_SW_FORCE_A_LO 4
`define OSC_SW_AMP0_SHUNT 3
`define OSC_SW_FORCE_B_HI 1
`define OSC_SW_FORCE_B_LO 0

// ----------------------------------------------------------------------------
// Force field codes and forced selections.
// ----------------------------------------------------------------------------
`define OSC_FORCE_NONE 2'h0
`define OSC_FORCE_INV0 2'h1
`define OSC_FORCE_INV1 2'h2
`define OSC_FORCED_INV0 2'h0
`define OSC_FORCED_INV1 2'h1

// ----------------------------------------------------------------------------
// Function select codes; all other codes are reserved.
// ----------------------------------------------------------------------------
`define OSC_FUNC_GENERAL 3'h0
`define OSC_FUNC_BUFFER 3'h1
`define OSC_FUNC_INVERTING 3'h6

// ----------------------------------------------------------------------------
// Bus answers.
// ----------------------------------------------------------------------------
`define OSC_RESP_OKAY 2'h0
`define OSC_RESP_SLVERR 2'h2

`endif

// ==== design/osc_pkg.sv ====
// Types of the amplifier control bank.
// Assumes the register header sits beside it.
`include "osc_regs.svh"

package osc_pkg;

  // Register selected by a bus address.
  typedef enum logic [2:0] {
    osc_sel_none,
    osc_sel_amp0_a,
    osc_sel_amp0_b,
    osc_sel_amp1_a,
    osc_sel_amp1_b,
    osc_sel_sw_word,
    osc_sel_sw_low
  } osc_sel_type;

  // Whole state of the bank, registered in one process.
  typedef struct packed {
    logic [7:0] amp0_control_a;
    logic [7:0] amp0_control_b;
    logic [7:0] amp1_control_a;
    logic [7:0] amp1_control_b;
    logic [15:0] switch_control_word;
    logic aw_held;
    logic [11:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [1:0] amp0_inv_sel;
    logic [1:0] amp1_inv_sel;
    logic [1:0] amp0_noninv_sel;
    logic [1:0] amp1_noninv_sel;
    logic [1:0] amp0_slew;
    logic [1:0] amp1_slew;
    logic [2:0] amp0_func;
    logic [2:0] amp1_func;
    logic amp0_cal;
    logic amp1_cal;
    logic amp0_shunt;
    logic amp1_shunt;
    logic ground_sw;
  } osc_state_type;

endpackage

// ==== design/osc_bank.sv ====
// Amplifier control and switch register bank behind an AXI4-Lite slave.
// Assumes one clock, a synchronous active-low reset, and a bus master that
// keeps to AXI4-Lite handshakes with at most one write and one read pending.
//
// What this block does
// - Calibration bit in register b enables calibration.
// - Ground switch bit shorts auxiliary node to ground.
// - Force code 01 gives inverting 00, function 110.
// - Force code 10 gives inverting 01, function 110.
// - Switch word at ce, high byte ce, low cf.
// - Amplifier registers at c0..c3, cleared at reset.
// - Amplifier 1 shunt bit shorts output to feedback.
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
`include "osc_regs.svh"

module osc_bank (
  input wire logic aclk, // Bank clock, 25 MHz.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic clk_en, // Freezes all state while low; reset still clears it.
  input wire logic [11:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [11:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  output logic [1:0] amp0_inv_sel, // Effective inverting input select, amp 0.
  output logic [1:0] amp1_inv_sel, // Effective inverting input select, amp 1.
  output logic [1:0] amp0_noninv_sel, // Non-inverting input select, amp 0.
  output logic [1:0] amp1_noninv_sel, // Non-inverting input select, amp 1.
  output logic [1:0] amp0_slew, // Slew and power select, amp 0.
  output logic [1:0] amp1_slew, // Slew and power select, amp 1.
  output logic [2:0] amp0_func, // Effective function select, amp 0.
  output logic [2:0] amp1_func, // Effective function select, amp 1.
  output logic amp0_cal, // Offset calibration enable, amp 0.
  output logic amp1_cal, // Offset calibration enable, amp 1.
  output logic amp0_shunt, // Amp 0 output shorted to feedback.
  output logic amp1_shunt, // Amp 1 output shorted to feedback.
  output logic ground_sw // Auxiliary switch node shorted to ground.
);

  // --------------------------------------------------------------------------
  // Address decoding
  // --------------------------------------------------------------------------

  // Maps a byte address to a register; only aligned words decode.
  function automatic osc_pkg::osc_sel_type decode_addr(input logic [11:0] addr);
    logic [9:0] idx;
    idx = addr[11:2];
    decode_addr = osc_pkg::osc_sel_none;
    if (addr[1:0] == 2'h0) begin
      if (idx == {2'h0, `OSC_IDX_AMP0_A}) decode_addr = osc_pkg::osc_sel_amp0_a;
      if (idx == {2'h0, `OSC_IDX_AMP0_B}) decode_addr = osc_pkg::osc_sel_amp0_b;
      if (idx == {2'h0, `OSC_IDX_AMP1_A}) decode_addr = osc_pkg::osc_sel_amp1_a;
      if (idx == {2'h0, `OSC_IDX_AMP1_B}) decode_addr = osc_pkg::osc_sel_amp1_b;
      if (idx == {2'h0, `OSC_IDX_SW_WORD}) decode_addr = osc_pkg::osc_sel_sw_word;
      if (idx == {2'h0, `OSC_IDX_SW_LOW}) decode_addr = osc_pkg::osc_sel_sw_low;
    end
  endfunction

  // Applies a force code to an inverting select and a function select.
  function automatic logic [4:0] apply_force(input logic [1:0] force_code,
                                             input logic [1:0] inv,
                                             input logic [2:0] func);
    apply_force = {inv, func};
    if (force_code == `OSC_FORCE_INV0) begin
      apply_force = {`OSC_FORCED_INV0, `OSC_FUNC_INVERTING};
    end else if (force_code == `OSC_FORCE_INV1) begin
      apply_force = {`OSC_FORCED_INV1, `OSC_FUNC_INVERTING};
    end
  endfunction

  // Merges an 8-bit write through byte lane 0.
  function automatic logic [7:0] merge_byte(input logic [7:0] old,
                                            input logic [31:0] data,
                                            input logic [3:0] strb);
    merge_byte = strb[0] ? data[7:0] : old;
  endfunction

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  osc_pkg::osc_state_type state;
  osc_pkg::osc_state_type next_state;

  // Computes the next state: bus handshakes, register writes, reads, outputs.
  always_comb begin
    osc_pkg::osc_sel_type wsel;
    osc_pkg::osc_sel_type rsel;
    logic [7:0] sw_low;
    logic [4:0] eff0;
    logic [4:0] eff1;
    wsel = osc_pkg::osc_sel_none;
    rsel = osc_pkg::osc_sel_none;
    sw_low = 8'h00;
    eff0 = 5'h00;
    eff1 = 5'h00;
    next_state = state;

    // Capture write address and data independently, in either order.
    if (s_axi_awvalid && state.awready) begin
      next_state.aw_held = 1'b1;
      next_state.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && state.wready) begin
      next_state.w_held = 1'b1;
      next_state.w_data = s_axi_wdata;
      next_state.w_strb = s_axi_wstrb;
    end

    // Retire the write response.
    if (state.bvalid && s_axi_bready) begin
      next_state.bvalid = 1'b0;
    end

    // Perform the write once both halves are held.
    if (state.aw_held && state.w_held && !state.bvalid) begin
      wsel = decode_addr(state.aw_addr);
      next_state.aw_held = 1'b0;
      next_state.w_held = 1'b0;
      next_state.bvalid = 1'b1;
      next_state.bresp = `OSC_RESP_OKAY;
      unique case (wsel)
        osc_pkg::osc_sel_amp0_a: begin
          next_state.amp0_control_a = merge_byte(state.amp0_control_a, state.w_data,
                                                 state.w_strb);
        end
        osc_pkg::osc_sel_amp0_b: begin
          next_state.amp0_control_b = merge_byte(state.amp0_control_b, state.w_data,
                                                 state.w_strb);
        end
        osc_pkg::osc_sel_amp1_a: begin
          next_state.amp1_control_a = merge_byte(state.amp1_control_a, state.w_data,
                                                 state.w_strb);
        end
        osc_pkg::osc_sel_amp1_b: begin
          next_state.amp1_control_b = merge_byte(state.amp1_control_b, state.w_data,
                                                 state.w_strb);
        end
        osc_pkg::osc_sel_sw_word: begin
          // Lane 0 writes the low byte, lane 1 the high byte.
          next_state.switch_control_word[7:0] = merge_byte(state.switch_control_word[7:0],
                                                           state.w_data, state.w_strb);
          if (state.w_strb[1]) begin
            next_state.switch_control_word[15:8] = state.w_data[15:8];
          end
        end
        osc_pkg::osc_sel_sw_low: begin
          next_state.switch_control_word[7:0] = merge_byte(state.switch_control_word[7:0],
                                                           state.w_data, state.w_strb);
        end
        osc_pkg::osc_sel_none: begin
          next_state.bresp = `OSC_RESP_SLVERR;
        end
      endcase
    end

    // Accept a read when no read data is pending; answer the next cycle.
    if (state.rvalid && s_axi_rready) begin
      next_state.rvalid = 1'b0;
    end
    if (s_axi_arvalid && state.arready) begin
      rsel = decode_addr(s_axi_araddr);
      next_state.rvalid = 1'b1;
      next_state.rresp = `OSC_RESP_OKAY;
      next_state.rdata = 32'h0000_0000;
      unique case (rsel)
        osc_pkg::osc_sel_amp0_a: next_state.rdata[7:0] = state.amp0_control_a;
        osc_pkg::osc_sel_amp0_b: next_state.rdata[7:0] = state.amp0_control_b;
        osc_pkg::osc_sel_amp1_a: next_state.rdata[7:0] = state.amp1_control_a;
        osc_pkg::osc_sel_amp1_b: next_state.rdata[7:0] = state.amp1_control_b;
        osc_pkg::osc_sel_sw_word: next_state.rdata[15:0] = state.switch_control_word;
        osc_pkg::osc_sel_sw_low: next_state.rdata[7:0] = state.switch_control_word[7:0];
        osc_pkg::osc_sel_none: next_state.rresp = `OSC_RESP_SLVERR;
      endcase
    end

    // Ready flags follow from what is held after this edge.
    next_state.awready = !next_state.aw_held;
    next_state.wready = !next_state.w_held;
    next_state.arready = !next_state.rvalid;

    // Analog controls from the registers as they stand after this edge.
    sw_low = next_state.switch_control_word[7:0];
    eff0 = apply_force(sw_low[`OSC_SW_FORCE_B_HI:`OSC_SW_FORCE_B_LO],
                       next_state.amp0_control_a[`OSC_A_INV_HI:`OSC_A_INV_LO],
                       next_state.amp0_control_b[`OSC_B_FUNC_HI:`OSC_B_FUNC_LO]);
    eff1 = apply_force(sw_low[`OSC_SW_FORCE_A_HI:`OSC_SW_FORCE_A_LO],
                       next_state.amp1_control_a[`OSC_A_INV_HI:`OSC_A_INV_LO],
                       next_state.amp1_control_b[`OSC_B_FUNC_HI:`OSC_B_FUNC_LO]);
    next_state.amp0_inv_sel = eff0[4:3];
    next_state.amp0_func = eff0[2:0];
    next_state.amp1_inv_sel = eff1[4:3];
    next_state.amp1_func = eff1[2:0];
    next_state.amp0_noninv_sel = next_state.amp0_control_a[`OSC_A_NONINV_HI:`OSC_A_NONINV_LO];
    next_state.amp1_noninv_sel = next_state.amp1_control_a[`OSC_A_NONINV_HI:`OSC_A_NONINV_LO];
    next_state.amp0_slew = next_state.amp0_control_a[`OSC_A_SLEW_HI:`OSC_A_SLEW_LO];
    next_state.amp1_slew = next_state.amp1_control_a[`OSC_A_SLEW_HI:`OSC_A_SLEW_LO];
    next_state.amp0_cal = next_state.amp0_control_b[`OSC_B_CAL];
    next_state.amp1_cal = next_state.amp1_control_b[`OSC_B_CAL];
    next_state.amp0_shunt = sw_low[`OSC_SW_AMP0_SHUNT];
    next_state.amp1_shunt = sw_low[`OSC_SW_AMP1_SHUNT];
    next_state.ground_sw = sw_low[`OSC_SW_GROUND];
  end

  // Registers the state; reset clears every register as power-up clear does, except the three ready flags, which it sets.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= '0;
      state.amp0_control_a <= `OSC_RST_BYTE;
      state.amp0_control_b <= `OSC_RST_BYTE;
      state.amp1_control_a <= `OSC_RST_BYTE;
      state.amp1_control_b <= `OSC_RST_BYTE;
      state.switch_control_word <= `OSC_RST_WORD;
      state.awready <= 1'b1;
      state.wready <= 1'b1;
      state.arready <= 1'b1;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs, each straight from a flip-flop
  // --------------------------------------------------------------------------
  assign s_axi_awready = state.awready;
  assign s_axi_wready = state.wready;
  assign s_axi_bvalid = state.bvalid;
  assign s_axi_bresp = state.bresp;
  assign s_axi_arready = state.arready;
  assign s_axi_rvalid = state.rvalid;
  assign s_axi_rdata = state.rdata;
  assign s_axi_rresp = state.rresp;
  assign amp0_inv_sel = state.amp0_inv_sel;
  assign amp1_inv_sel = state.amp1_inv_sel;
  assign amp0_noninv_sel = state.amp0_noninv_sel;
  assign amp1_noninv_sel = state.amp1_noninv_sel;
  assign amp0_slew = state.amp0_slew;
  assign amp1_slew = state.amp1_slew;
  assign amp0_func = state.amp0_func;
  assign amp1_func = state.amp1_func;
  assign amp0_cal = state.amp0_cal;
  assign amp1_cal = state.amp1_cal;
  assign amp0_shunt = state.amp0_shunt;
  assign amp1_shunt = state.amp1_shunt;
  assign ground_sw = state.ground_sw;

endmodule

// ==== sim/osc_bank_asserts.sv ====
// Concurrent checks on the ports of the amplifier control bank.
// Assumes one clock and a synchronous active-low reset; bound into osc_bank below.
`timescale 1ns/1ps
`include "osc_regs.svh"

module osc_bank_asserts (
  input wire logic aclk, // Bank clock.
  input wire logic aresetn, // Reset, active low.
  input wire logic clk_en, // Clock enable.
  input wire logic [11:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Address valid.
  input wire logic s_axi_awready, // Address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Byte strobes.
  input wire logic s_axi_wvalid, // Data valid.
  input wire logic s_axi_wready, // Data ready.
  input wire logic [1:0] s_axi_bresp, // Write answer.
  input wire logic s_axi_bvalid, // Answer valid.
  input wire logic [1:0] amp0_inv_sel, // Inverting select, amp 0.
  input wire logic [1:0] amp1_inv_sel, // Inverting select, amp 1.
  input wire logic [2:0] amp0_func, // Function, amp 0.
  input wire logic [2:0] amp1_func, // Function, amp 1.
  input wire logic amp0_cal, // Calibration, amp 0.
  input wire logic amp1_cal, // Calibration, amp 1.
  input wire logic amp1_shunt, // Shunt, amp 1.
  input wire logic ground_sw // Ground switch.
);
  localparam logic [11:0] A0B = {2'h0, `OSC_IDX_AMP0_B, 2'h0};
  localparam logic [11:0] ASW = {2'h0, `OSC_IDX_SW_WORD, 2'h0};
  localparam logic [11:0] ALO = {2'h0, `OSC_IDX_SW_LOW, 2'h0};
  logic [11:0] aw_q;
  logic [31:0] w_q;
  logic [3:0] s_q;
  logic [7:0] sw_q;
  logic bv_q;
  logic wr;
  logic sw_lo;
  logic hit;

  // --------------------------------------------------------------------------
  // Helper logic
  // --------------------------------------------------------------------------
  // Marks the cycle a write commits and classifies its address.
  always_comb begin
    wr = s_axi_bvalid && !bv_q;
    sw_lo = (aw_q == ASW || aw_q == ALO) && s_q[0];
    hit = (aw_q[1:0] == 2'h0) && (aw_q[11:2] inside {10'h0c0, 10'h0c1, 10'h0c2,
      10'h0c3, 10'h0ce, 10'h0cf});
  end

  // Captures each taken write and the switch low byte it leaves behind.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bv_q <= 1'b0;
      sw_q <= 8'h00;
    end else begin
      bv_q <= s_axi_bvalid;
      if (wr && sw_lo) begin
        sw_q <= w_q[7:0];
      end
    end
    if (clk_en && s_axi_awvalid && s_axi_awready) begin
      aw_q <= s_axi_awaddr;
    end
    if (clk_en && s_axi_wvalid && s_axi_wready) begin
      w_q <= s_axi_wdata;
      s_q <= s_axi_wstrb;
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  cal_follows_a: assert property (wr && aw_q == A0B && s_q[0] |-> amp0_cal == w_q[1])
    else $error("Calibration enable does not follow its bit.");
  ground_sw_a: assert property (wr && sw_lo |-> ground_sw == w_q[6])
    else $error("Ground switch does not follow its bit.");
  force_low_a: assert property (wr && sw_lo && w_q[5:4] == `OSC_FORCE_INV0 |->
    amp1_inv_sel == `OSC_FORCED_INV0 && amp1_func == `OSC_FUNC_INVERTING)
    else $error("Force code 01 not applied to amp 1.");
  force_high_a: assert property (wr && sw_lo && w_q[1:0] == `OSC_FORCE_INV1 |->
    amp0_inv_sel == `OSC_FORCED_INV1 && amp0_func == `OSC_FUNC_INVERTING)
    else $error("Force code 10 not applied to amp 0.");
  bad_addr_a: assert property (wr && !hit |-> s_axi_bresp == `OSC_RESP_SLVERR)
    else $error("Unmapped write not refused.");
  reset_clear_a: assert property ($rose(aresetn) |-> {amp0_cal, amp1_cal, amp0_func,
    amp1_func, amp0_inv_sel, amp1_inv_sel, ground_sw, amp1_shunt} == 14'h0000)
    else $error("Outputs not cleared by reset.");
  shunt_one_a: assert property (wr && sw_lo |-> amp1_shunt == w_q[7])
    else $error("Amp 1 shunt does not follow its bit.");
  func_pass_a: assert property (wr && aw_q == A0B && s_q[0] && sw_q[1:0] != 2'h1 &&
    sw_q[1:0] != 2'h2 |-> amp0_func == w_q[4:2])
    else $error("Function select not passed through.");

  cover property (wr && sw_lo && w_q[5:4] == `OSC_FORCE_INV0);
  cover property (wr && !hit);
  cover property (wr && aw_q == A0B && w_q[1]);
endmodule

bind osc_bank osc_bank_asserts u_asserts (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .amp0_inv_sel(amp0_inv_sel), .amp1_inv_sel(amp1_inv_sel), .amp0_func(amp0_func),
  .amp1_func(amp1_func), .amp0_cal(amp0_cal), .amp1_cal(amp1_cal),
  .amp1_shunt(amp1_shunt), .ground_sw(ground_sw));

// ==== sim/osc_bank_tb.sv ====
// Self-checking bench for the amplifier control bank over AXI4-Lite.
// Assumes the design files and the register header are compiled first.
`timescale 1ns/1ps
`include "osc_regs.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; \
  $display("BAD %s expected %h seen %h", nm, e, g); end end

module osc_bank_tb;
  localparam logic [11:0] A0A = {2'h0, `OSC_IDX_AMP0_A, 2'h0};
  localparam logic [11:0] A0B = {2'h0, `OSC_IDX_AMP0_B, 2'h0};
  localparam logic [11:0] A1A = {2'h0, `OSC_IDX_AMP1_A, 2'h0};
  localparam logic [11:0] A1B = {2'h0, `OSC_IDX_AMP1_B, 2'h0};
  localparam logic [11:0] ASW = {2'h0, `OSC_IDX_SW_WORD, 2'h0};
  localparam logic [11:0] ALO = {2'h0, `OSC_IDX_SW_LOW, 2'h0};
  localparam logic [1:0] OK = `OSC_RESP_OKAY;
  localparam logic [1:0] ERR = `OSC_RESP_SLVERR;
  logic aclk, aresetn, clk_en, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, c0, c1, h0, h1, gs;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, i0, i1, n0, n1, s0, s1;
  logic [2:0] f0, f1;
  logic [11:0] amap [6] = '{A0A, A0B, A1A, A1B, ASW, ALO};
  logic [2:0] fcode [3] = '{`OSC_FUNC_GENERAL, `OSC_FUNC_BUFFER, `OSC_FUNC_INVERTING};
  int err_total = 0;
  int n_tests = 0;

  osc_bank uut (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .amp0_inv_sel(i0), .amp1_inv_sel(i1), .amp0_noninv_sel(n0), .amp1_noninv_sel(n1),
    .amp0_slew(s0), .amp1_slew(s1), .amp0_func(f0), .amp1_func(f1), .amp0_cal(c0),
    .amp1_cal(c1), .amp0_shunt(h0), .amp1_shunt(h1), .ground_sw(gs));

  // Free-running 25 MHz clock.
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // One write: address and data offered together, each released when taken.
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
      input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) begin
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
      end
    end while (bvalid !== 1'b1 && n < 64);
    bready <= 1'b0;
    if (bvalid !== 1'b1) begin
      err_total++;
      results();
    end
    `CHK("bresp", er, bresp)
  endtask

  // One read: address held until taken, data taken at the answer edge.
  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) begin
        arvalid <= 1'b0;
      end
    end while (rvalid !== 1'b1 && n < 64);
    rready <= 1'b0;
    if (rvalid !== 1'b1) begin
      err_total++;
      results();
    end
    `CHK("rdata", ed, rdata)
    `CHK("rresp", er, rresp)
  endtask

  // Main sequence: reset, then register, switch, force and error checks.
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata, wstrb} = '0;
    clk_en = 1'b1;
    aresetn = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (amap[k]) rd(amap[k], 32'h0, OK);
    for (int k = 0; k < 4; k++) begin
      wr(amap[k], {24'hffffff, 8'h3c + 8'(k)}, 4'hf, OK);
      rd(amap[k], {24'h0, 8'h3c + 8'(k)}, OK);
      wr(amap[k], 32'h0, 4'hf, OK);
    end
    wr(A0B, 32'h2, 4'h1, OK);
    wr(A1B, 32'h2, 4'h1, OK);
    `CHK("cal on", 2'h3, {c1, c0})
    wr(A0B, 32'h0, 4'h1, OK);
    `CHK("cal off", 2'h2, {c1, c0})
    foreach (fcode[k]) begin
      wr(A0B, {27'h0, fcode[k], 2'h0}, 4'h1, OK);
      wr(A1B, {27'h0, fcode[k], 2'h0}, 4'h1, OK);
      `CHK("func", {fcode[k], fcode[k]}, {f1, f0})
    end
    wr(A1A, 32'hb4, 4'h1, OK);
    `CHK("amp1 a fields", 6'h2d, {i1, n1, s1})
    wr(A0A, 32'h78, 4'h1, OK);
    `CHK("amp0 a fields", 6'h1e, {i0, n0, s0})
    wr(ALO, 32'h48, 4'h1, OK);
    `CHK("switches 48", 3'h5, {gs, h1, h0})
    wr(ALO, 32'h80, 4'h1, OK);
    `CHK("switches 80", 3'h2, {gs, h1, h0})
    // Amp 1 programs inverting 10, buffer; amp 0 programs inverting 11, general.
    wr(A1B, 32'h04, 4'h1, OK);
    wr(A0A, 32'hc0, 4'h1, OK);
    wr(A0B, 32'h00, 4'h1, OK);
    wr(ALO, 32'h11, 4'h1, OK);
    `CHK("force 01", 10'h0c6, {i1, f1, i0, f0})
    wr(ALO, 32'h22, 4'h1, OK);
    `CHK("force 10", 10'h1ce, {i1, f1, i0, f0})
    rd(A1A, 32'hb4, OK);
    wr(ALO, 32'h00, 4'h1, OK);
    `CHK("force 00", 10'h238, {i1, f1, i0, f0})
    wr(ASW, 32'hffff1234, 4'h3, OK);
    rd(ASW, 32'h1234, OK);
    rd(ALO, 32'h34, OK);
    wr(ALO, 32'h5a, 4'h1, OK);
    rd(ASW, 32'h125a, OK);
    wr(ASW, 32'h0000ab00, 4'h2, OK);
    rd(ASW, 32'hab5a, OK);
    wr(12'h310, 32'hff, 4'h1, ERR);
    rd(12'h310, 32'h0, ERR);
    wr(12'h301, 32'hff, 4'h1, ERR);
    rd(A0A, 32'hc0, OK);
    // A second reset in mid-run must clear the whole bank again.
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    `CHK("outputs after reset", 15'h0, {gs, h1, h0, c1, c0, f1, f0, i1, i0})
    rd(ASW, 32'h0, OK);
    rd(A0A, 32'h0, OK);
    results();
  end
endmodule
